// [include/otp_reload_pkg.sv]
// Package: constants and types of the output window and reload logic.
// Assumes a 200 MHz system clock.
`default_nettype none
package otp_reload_pkg;
   // ---------------------------------------------
   // Clock and times
   // ---------------------------------------------
   localparam int CLK_KHZ  = 200_000;
   localparam int TICK_MS  = 10;   // Count step
   localparam int IDLE_MS  = 1000; // Inactivity window
   localparam int POWER_MS = 25;   // Output hold-off
   localparam int TICK_CYC  = TICK_MS * CLK_KHZ;
   localparam int IDLE_CYC  = IDLE_MS * CLK_KHZ;
   localparam int POWER_CYC = POWER_MS * CLK_KHZ;
   localparam int BAUD      = 9600;
   localparam int BIT_CYC   = (CLK_KHZ * 1000) / BAUD;
   // ---------------------------------------------
   // Widths and sizes
   // ---------------------------------------------
   localparam int TIMER_W = 28;
   localparam int BIT_W   = 16;
   localparam int PTR_N   = 4;
   localparam int BANK_W  = 3;
   localparam int FRAME_W = 10;
   typedef logic [TIMER_W-1:0] timer_t;
   typedef logic [BIT_W-1:0]   bitcnt_t;
   typedef logic [7:0]         count_t;
   // One bank pointer cell: programmed flag and bank number
   typedef struct packed {
      logic              programmed;
      logic [BANK_W-1:0] bank;
   } bank_pointer_s;
   typedef enum logic [2:0] {
      ST_POWER, ST_POWER_LOAD, ST_STEADY,
      ST_WINDOW, ST_WATCH, ST_RELOAD
   } ctrl_state_e;
endpackage
`default_nettype wire

// [src/otp_reload.sv]
// Output window, inactivity timer and OTP reload control.
// Assumes a serial engine that decodes received bytes from
// line_level and writes output_on_count; OTP and checksum
// logic lie outside and answer load requests.
//
// Overview of operation
// - Line is serial while output disabled
// - Non-zero count write enables output
// - Count decrements every 10 ms to zero
// - At zero disable output, start 1 s
// - Line activity restarts the 1 s period
// - Idle 1 s: check checksum, keep RAM
// - Bad checksum: highest programmed pointer wins
// - Pointer selects bank, bank loads RAM
// - Power-on uses last programmed pointer
// - Banks programmable independently of pointers
// - 25 ms hold-off, load, enable if good
// - Byte is start, 8 bits LSB first, stop
// - Pin driver only pulls low
`default_nettype none
module otp_reload #(
   parameter int TICK_CYCLES  = otp_reload_pkg::TICK_CYC,
   parameter int IDLE_CYCLES  = otp_reload_pkg::IDLE_CYC,
   parameter int POWER_CYCLES = otp_reload_pkg::POWER_CYC,
   parameter int BIT_CYCLES   = otp_reload_pkg::BIT_CYC
) (
   input  wire logic                           sys_clk,
   input  wire logic                           rst,
   input  wire logic                           wire_in,
   output logic                                wire_out,
   output logic                                wire_oe,
   output logic                                line_level,
   input  wire logic                           tx_valid,
   input  wire logic [7:0]                     tx_data,
   output logic                                tx_ready,
   input  wire logic                           count_wr,
   input  wire otp_reload_pkg::count_t         count_wr_data,
   output otp_reload_pkg::count_t              output_on_count,
   output logic                                sensor_output,
   input  wire logic                           ram_checksum_ok,
   input  wire otp_reload_pkg::bank_pointer_s  pointers [otp_reload_pkg::PTR_N],
   output logic                                load_req,
   output logic [otp_reload_pkg::BANK_W-1:0]   load_bank,
   input  wire logic                           load_done,
   input  wire logic                           load_checksum_ok,
   input  wire logic                           bank_prog_req,
   output logic                                bank_prog_en
);
   // ---------------------------------------------
   // Constants at counter width
   // ---------------------------------------------
   localparam otp_reload_pkg::timer_t TICK_LAST =
      otp_reload_pkg::timer_t'(TICK_CYCLES - 1);
   localparam otp_reload_pkg::timer_t IDLE_LAST =
      otp_reload_pkg::timer_t'(IDLE_CYCLES - 1);
   localparam otp_reload_pkg::timer_t POWER_LAST =
      otp_reload_pkg::timer_t'(POWER_CYCLES - 1);
   localparam otp_reload_pkg::bitcnt_t BIT_LAST =
      otp_reload_pkg::bitcnt_t'(BIT_CYCLES - 1);
   localparam otp_reload_pkg::count_t COUNT_ONE = 8'h01;
   localparam logic [3:0] FRAME_LAST = 4'(otp_reload_pkg::FRAME_W - 1);

   // ---------------------------------------------
   // Line synchroniser and edge filter
   // ---------------------------------------------
   logic sync1_reg, sync2_reg, sync3_reg, level_reg;
   logic level_next;
   logic line_fall;

   // A change counts only once stages two and three agree
   always_comb begin
      level_next = level_reg;
      if (sync2_reg == sync3_reg) begin
         level_next = sync3_reg;
      end
   end
   assign line_fall  = level_reg & ~level_next;
   assign line_level = level_reg;

   // Idle line is high, so reset to one avoids a false edge
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         sync1_reg <= 1'b1;
         sync2_reg <= 1'b1;
         sync3_reg <= 1'b1;
         level_reg <= 1'b1;
      end else begin
         sync1_reg <= wire_in;
         sync2_reg <= sync1_reg;
         sync3_reg <= sync2_reg;
         level_reg <= level_next;
      end
   end

   // ---------------------------------------------
   // Highest programmed pointer
   // ---------------------------------------------
   logic                              ptr_found;
   logic [otp_reload_pkg::BANK_W-1:0] ptr_bank;

   // Scan upward so the last programmed cell wins
   always_comb begin
      ptr_found = 1'b0;
      ptr_bank  = '0;
      for (int i = 0; i < otp_reload_pkg::PTR_N; i++) begin
         if (pointers[i].programmed) begin
            ptr_found = 1'b1;
            ptr_bank  = pointers[i].bank;
         end
      end
   end

   // ---------------------------------------------
   // Control state machine
   // ---------------------------------------------
   otp_reload_pkg::ctrl_state_e       state_reg, state_next;
   otp_reload_pkg::timer_t            timer_reg, timer_next;
   otp_reload_pkg::count_t            count_reg, count_next;
   logic                              en_reg, en_next;
   logic                              req_reg, req_next;
   logic [otp_reload_pkg::BANK_W-1:0] bank_reg, bank_next;
   logic                              open_state;

   assign open_state = (state_reg == otp_reload_pkg::ST_STEADY)
                     | (state_reg == otp_reload_pkg::ST_WINDOW)
                     | (state_reg == otp_reload_pkg::ST_WATCH);

   // One timer serves hold-off, count step and idle watch
   always_comb begin
      state_next = state_reg;
      timer_next = timer_reg + 1'b1;
      count_next = count_reg;
      en_next    = en_reg;
      req_next   = 1'b0;
      bank_next  = bank_reg;
      case (state_reg)
         otp_reload_pkg::ST_POWER: begin
            en_next = 1'b0;
            if (timer_reg == POWER_LAST) begin
               if (ptr_found) begin
                  req_next   = 1'b1;
                  bank_next  = ptr_bank;
                  state_next = otp_reload_pkg::ST_POWER_LOAD;
               end else begin
                  state_next = otp_reload_pkg::ST_STEADY;
               end
            end
         end
         otp_reload_pkg::ST_POWER_LOAD: begin
            if (load_done) begin
               en_next    = load_checksum_ok;
               state_next = otp_reload_pkg::ST_STEADY;
            end
         end
         otp_reload_pkg::ST_WINDOW: begin
            if (timer_reg == TICK_LAST) begin
               timer_next = '0;
               count_next = count_reg - COUNT_ONE;
               if (count_reg == COUNT_ONE) begin
                  en_next    = 1'b0;
                  state_next = otp_reload_pkg::ST_WATCH;
               end
            end
         end
         otp_reload_pkg::ST_WATCH: begin
            if (line_fall) begin
               timer_next = '0;
            end else if (timer_reg == IDLE_LAST) begin
               if (ram_checksum_ok || !ptr_found) begin
                  state_next = otp_reload_pkg::ST_STEADY;
               end else begin
                  req_next   = 1'b1;
                  bank_next  = ptr_bank;
                  state_next = otp_reload_pkg::ST_RELOAD;
               end
            end
         end
         otp_reload_pkg::ST_RELOAD: begin
            if (load_done) begin
               state_next = otp_reload_pkg::ST_STEADY;
            end
         end
         otp_reload_pkg::ST_STEADY: begin
            timer_next = '0;
         end
         default: begin
            state_next = otp_reload_pkg::ST_POWER;
            timer_next = '0;
         end
      endcase
      // A new count overrides the window in any open state
      if (count_wr && open_state) begin
         count_next = count_wr_data;
         timer_next = '0;
         if (count_wr_data != '0) begin
            en_next    = 1'b1;
            state_next = otp_reload_pkg::ST_WINDOW;
         end else if (state_reg == otp_reload_pkg::ST_WINDOW) begin
            en_next    = 1'b0;
            state_next = otp_reload_pkg::ST_WATCH;
         end
      end
   end

   // Registers only
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         state_reg <= otp_reload_pkg::ST_POWER;
         timer_reg <= '0;
         count_reg <= '0;
         en_reg    <= 1'b0;
         req_reg   <= 1'b0;
         bank_reg  <= '0;
      end else begin
         state_reg <= state_next;
         timer_reg <= timer_next;
         count_reg <= count_next;
         en_reg    <= en_next;
         req_reg   <= req_next;
         bank_reg  <= bank_next;
      end
   end

   assign output_on_count = count_reg;
   assign sensor_output   = en_reg;
   assign load_req        = req_reg;
   assign load_bank       = bank_reg;
   // Bank writes never look at the pointer cells
   assign bank_prog_en    = bank_prog_req;

   // ---------------------------------------------
   // Byte transmitter
   // ---------------------------------------------
   logic [otp_reload_pkg::FRAME_W-1:0] shift_reg, shift_next;
   otp_reload_pkg::bitcnt_t            baud_reg, baud_next;
   logic [3:0]                         nbit_reg, nbit_next;
   logic                               busy_reg, busy_next;

   // Refuse bytes while the analog output owns the line
   assign tx_ready = ~busy_reg & ~en_reg;

   // Frame is stop, data, start; shifted out LSB first
   always_comb begin
      shift_next = shift_reg;
      baud_next  = baud_reg;
      nbit_next  = nbit_reg;
      busy_next  = busy_reg;
      if (!busy_reg) begin
         if (tx_valid && tx_ready) begin
            shift_next = {1'b1, tx_data, 1'b0};
            baud_next  = '0;
            nbit_next  = '0;
            busy_next  = 1'b1;
         end
      end else if (baud_reg == BIT_LAST) begin
         baud_next  = '0;
         shift_next = {1'b1, shift_reg[otp_reload_pkg::FRAME_W-1:1]};
         nbit_next  = nbit_reg + 1'b1;
         if (nbit_reg == FRAME_LAST) begin
            busy_next = 1'b0;
         end
      end else begin
         baud_next = baud_reg + 1'b1;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         shift_reg <= '1;
         baud_reg  <= '0;
         nbit_reg  <= '0;
         busy_reg  <= 1'b0;
      end else begin
         shift_reg <= shift_next;
         baud_reg  <= baud_next;
         nbit_reg  <= nbit_next;
         busy_reg  <= busy_next;
      end
   end

   // Open drain: a zero bit pulls low, a one lets pull-up win
   assign wire_out = 1'b0;
   assign wire_oe  = busy_reg & ~shift_reg[0] & ~en_reg;

   // ---------------------------------------------
   // Checks
   // ---------------------------------------------
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (rst);

   count_enable_a: assert property (
      count_wr && open_state && count_wr_data != '0
      |=> sensor_output && output_on_count == $past(count_wr_data))
      else $error("Non-zero count did not enable output");
   count_step_a: assert property (
      state_reg == otp_reload_pkg::ST_WINDOW && timer_reg == TICK_LAST
      && !count_wr |=> output_on_count == $past(output_on_count) - 8'h01)
      else $error("Count did not step down on tick");
   window_end_a: assert property (
      state_reg == otp_reload_pkg::ST_WINDOW && timer_reg == TICK_LAST
      && count_reg == COUNT_ONE && !count_wr
      |=> !sensor_output && state_reg == otp_reload_pkg::ST_WATCH
      && timer_reg == '0)
      else $error("Window end did not disable output");
   idle_restart_a: assert property (
      state_reg == otp_reload_pkg::ST_WATCH && line_fall && !count_wr
      |=> timer_reg == '0)
      else $error("Line activity did not restart timer");
   checksum_keep_a: assert property (
      state_reg == otp_reload_pkg::ST_WATCH && timer_reg == IDLE_LAST
      && !line_fall && !count_wr && ram_checksum_ok
      |=> state_reg == otp_reload_pkg::ST_STEADY && !load_req)
      else $error("Good checksum still reloaded");
   reload_bank_a: assert property (
      $rose(load_req) |-> load_bank == $past(ptr_bank)
      && $past(ptr_found))
      else $error("Reload used wrong pointer");
   hold_off_a: assert property (
      state_reg == otp_reload_pkg::ST_POWER |-> !sensor_output)
      else $error("Output on during hold-off");
   power_enable_a: assert property (
      state_reg == otp_reload_pkg::ST_POWER_LOAD && load_done
      |=> sensor_output == $past(load_checksum_ok))
      else $error("Power load enable mismatch");
   pin_share_a: assert property (
      sensor_output |-> !wire_oe ##0 wire_out == 1'b0)
      else $error("Pin driven while output enabled");
   start_bit_a: assert property (
      tx_valid && tx_ready |=> wire_oe [*2])
      else $error("Start bit not driven low");

   window_c: cover property (
      state_reg == otp_reload_pkg::ST_WINDOW ##1
      state_reg == otp_reload_pkg::ST_WATCH);
   reload_c: cover property (
      state_reg == otp_reload_pkg::ST_RELOAD ##[1:50] load_done);
   restart_c: cover property (
      state_reg == otp_reload_pkg::ST_WATCH && line_fall);
   frame_c: cover property ($fell(busy_reg));

endmodule // otp_reload
`default_nettype wire

// [verification/line_ctrl_model.sv]
// Calibration controller model on the shared single-wire line.
// Assumes a pull-up: the line reads high unless some party pulls low.
`default_nettype none
module line_ctrl_model #(
   parameter int BIT_CYCLES = 4
) (
   input  wire logic       sys_clk,
   input  wire logic       line,
   output logic            pull_low,
   output logic [7:0]      rx_byte,
   output logic            rx_stop
);
   timeunit 1ns;
   timeprecision 1ps;
   // Released line until a byte is sent
   initial begin
      pull_low = 1'b0;
      rx_byte  = 8'h00;
      rx_stop  = 1'b0;
   end
   // Open drain send: a zero bit pulls low, a one bit lets the pull-up win
   task automatic send_byte(input logic [7:0] data);
      logic [9:0] frame;
      frame = {1'b1, data, 1'b0};
      for (int i = 0; i < 10; i++) begin
         @(posedge sys_clk);
         pull_low <= ~frame[i];
         repeat (BIT_CYCLES - 1) @(posedge sys_clk);
      end
   endtask
   // Receiver samples mid-bit; own frames are skipped
   always begin
      @(negedge line);
      if (!pull_low) begin
         repeat (BIT_CYCLES / 2) @(posedge sys_clk);
         for (int i = 0; i < 8; i++) begin
            repeat (BIT_CYCLES) @(posedge sys_clk);
            rx_byte[i] = line;
         end
         repeat (BIT_CYCLES) @(posedge sys_clk);
         rx_stop = line;
      end
   end
endmodule // line_ctrl_model
`default_nettype wire

// [verification/timed_output_window_otp_reload_bench.sv]
// Bench for the output window and reload control.
// Assumes short timing parameters; loader and checksum are modelled here.
`default_nettype none
module timed_output_window_otp_reload_bench;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int TICK = 20;
   localparam int IDLE = 50;
   localparam int POWER = 30;
   localparam int BITC = 4;
   typedef struct packed {
      otp_reload_pkg::count_t value;
      logic                   out_on;
   } row_s;
   row_s rows [5] = '{'{8'h01, 1'b1}, '{8'hFF, 1'b1}, '{8'h00, 1'b0},
                      '{8'h80, 1'b1}, '{8'h00, 1'b0}};
   logic sys_clk = 1'b0, rst = 1'b1, line, ctrl_pull, rx_stop;
   logic wire_out, wire_oe, line_level, tx_valid = 1'b0, tx_ready;
   logic [7:0] tx_data = 8'h00, rx_byte;
   logic count_wr = 1'b0, sensor_output, ram_checksum_ok = 1'b0;
   otp_reload_pkg::count_t count_wr_data = 8'h00, output_on_count;
   otp_reload_pkg::bank_pointer_s pointers [otp_reload_pkg::PTR_N];
   logic load_req, load_done = 1'b0, load_checksum_ok = 1'b1;
   logic [2:0] load_bank;
   logic [1:0] pend = 2'b00;
   logic bank_prog_req = 1'b0, bank_prog_en;
   int bad_count = 0, tests_run = 0, load_count = 0, n;
   // ----------
   // Clock, line and partners
   // ----------
   always #2.5 sys_clk = ~sys_clk;
   // Pull-up wins unless either party pulls low
   assign line = (wire_oe ? wire_out : 1'b1) & ~ctrl_pull;
   // Loader answers four cycles after each request
   always @(posedge sys_clk) begin
      load_done <= (pend == 2'b01);
      if (load_req === 1'b1) begin
         pend <= 2'b11;
         load_count <= load_count + 1;
      end else if (pend != 2'b00) begin
         pend <= pend - 2'b01;
      end
   end
   otp_reload #(.TICK_CYCLES(TICK), .IDLE_CYCLES(IDLE), .POWER_CYCLES(POWER),
      .BIT_CYCLES(BITC)) otp_reload_inst (.sys_clk(sys_clk), .rst(rst),
      .wire_in(line), .wire_out(wire_out), .wire_oe(wire_oe),
      .line_level(line_level), .tx_valid(tx_valid), .tx_data(tx_data),
      .tx_ready(tx_ready), .count_wr(count_wr), .count_wr_data(count_wr_data),
      .output_on_count(output_on_count), .sensor_output(sensor_output),
      .ram_checksum_ok(ram_checksum_ok), .pointers(pointers),
      .load_req(load_req), .load_bank(load_bank), .load_done(load_done),
      .load_checksum_ok(load_checksum_ok), .bank_prog_req(bank_prog_req),
      .bank_prog_en(bank_prog_en));
   line_ctrl_model #(.BIT_CYCLES(BITC)) line_ctrl_model_inst (.sys_clk(sys_clk),
      .line(line), .pull_low(ctrl_pull), .rx_byte(rx_byte), .rx_stop(rx_stop));
   // ----------
   // Tasks
   // ----------
   task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
      tests_run++;
      if (seen !== exp) begin
         bad_count++;
         $display("[FAIL] %s exp %h seen %h", name, exp, seen);
      end
   endtask
   task automatic complete_run();
      $display("checks %0d errors %0d", tests_run, bad_count);
      if (bad_count == 0 && tests_run > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   // One-cycle write pulse, then let the answer settle
   task automatic cw(input logic [7:0] v);
      @(posedge sys_clk);
      count_wr <= 1'b1;
      count_wr_data <= v;
      @(posedge sys_clk);
      count_wr <= 1'b0;
      @(posedge sys_clk);
      #1;
   endtask
   // Bounded wait for a load request; n is the cycles spent
   task automatic wait_load();
      n = 0;
      while (load_req !== 1'b1 && n < 300) begin
         @(posedge sys_clk);
         #1;
         n++;
      end
      // A request that never came counts against the run
      if (load_req !== 1'b1) begin
         bad_count++;
      end
   endtask
   // Watchdog: whole run is well under this span
   initial begin
      repeat (6000) @(posedge sys_clk);
      bad_count++;
      complete_run();
   end
   // ----------
   // Main sequence
   // ----------
   initial begin
      pointers = '{'{1'b1, 3'd1}, '{1'b1, 3'd2}, '{1'b0, 3'd0}, '{1'b0, 3'd0}};
      repeat (6) @(posedge sys_clk);
      rst <= 1'b0;
      cw(8'h05); // Refused during hold-off
      check("holdoff_count", output_on_count, 8'h00);
      wait_load();
      check("holdoff_len", 8'(n >= POWER - 4 && n <= POWER + 4), 8'h01);
      check("holdoff_out", 8'(sensor_output), 8'h00);
      check("por_bank", 8'(load_bank), 8'h02);
      repeat (6) @(posedge sys_clk);
      #1;
      check("por_out", 8'(sensor_output), 8'h01);
      check("tx_blocked", 8'(tx_ready), 8'h00);
      // Ordinary writes: value and resulting output state
      foreach (rows[i]) begin
         cw(rows[i].value);
         check("row_count", output_on_count, rows[i].value);
         check("row_out", 8'(sensor_output), 8'(rows[i].out_on));
      end
      // Three steps of the window, then output off
      cw(8'h03);
      for (n = 0; n < 300 && sensor_output !== 1'b0; n++) begin
         @(posedge sys_clk);
         #1;
      end
      check("window_len", 8'(n >= 3 * TICK - 4 && n <= 3 * TICK), 8'h01);
      check("window_count", output_on_count, 8'h00);
      #1;
      check("tx_free", 8'(tx_ready), 8'h01);
      // Device sends a byte: open drain, framed, LSB first
      @(posedge sys_clk);
      tx_valid <= 1'b1;
      tx_data <= 8'hA5;
      @(posedge sys_clk);
      tx_valid <= 1'b0;
      #1;
      check("start_low", 8'(wire_oe), 8'h01);
      repeat (BITC) @(posedge sys_clk);
      #1;
      check("line_seen", 8'(line_level), 8'h00);
      check("tx_busy", 8'(tx_ready), 8'h00);
      repeat (11 * BITC) @(posedge sys_clk);
      check("tx_byte", rx_byte, 8'hA5);
      check("tx_stop", 8'(rx_stop), 8'h01);
      check("drive_low", 8'(wire_out), 8'h00);
      // Activity mid-watch restarts the idle period; the own frame's
      // last falling edge already restarted it, so send well before it ends
      pointers[2] <= '{1'b1, 3'd5};
      repeat (IDLE - 30) @(posedge sys_clk);
      line_ctrl_model_inst.send_byte(8'h55);
      check("restart", 8'(load_count), 8'h01);
      wait_load();
      check("restart_len", 8'(n >= IDLE - 16 && n <= IDLE), 8'h01);
      check("top_bank", 8'(load_bank), 8'h05);
      // Fourth pointer programmed last: it takes priority
      repeat (6) @(posedge sys_clk);
      pointers[3] <= '{1'b1, 3'd6};
      cw(8'h01);
      wait_load();
      check("next_bank", 8'(load_bank), 8'h06);
      check("reload_out", 8'(sensor_output), 8'h00);
      // Good checksum: no reload at all
      repeat (6) @(posedge sys_clk);
      ram_checksum_ok <= 1'b1;
      cw(8'h01);
      repeat (TICK + IDLE + 20) @(posedge sys_clk);
      check("keep_ram", 8'(load_count), 8'h03);
      // Bank programming passes through whatever the pointers say
      bank_prog_req <= 1'b1;
      @(posedge sys_clk);
      #1;
      check("prog_on", 8'(bank_prog_en), 8'h01);
      @(posedge sys_clk);
      bank_prog_req <= 1'b0;
      #1;
      check("prog_off", 8'(bank_prog_en), 8'h00);
      // Second reset with a bad bank checksum: output stays off
      @(posedge sys_clk);
      rst <= 1'b1;
      load_checksum_ok <= 1'b0;
      repeat (6) @(posedge sys_clk);
      rst <= 1'b0;
      wait_load();
      check("bad_por_bank", 8'(load_bank), 8'h06);
      repeat (6) @(posedge sys_clk);
      #1;
      check("bad_por_out", 8'(sensor_output), 8'h00);
      complete_run();
   end
endmodule // timed_output_window_otp_reload_bench
`default_nettype wire
